// ---- hw/sesp_slave.sv ----
`timescale 1ns/1ps
// Contract
// - serial clock is only an input; device is always slave
// - receive on data-in only, transmit on data-out only
// - every byte shifts most significant bit first
// - first full byte after select falls is the opcode
// - bad opcode: ignore further input, data-out high impedance until reselect
// - new select fall restarts sequence and clears bad-opcode state
// - deselected: data-in ignored, data-out high impedance
// - pause freezes sequence without reset; shifting resumes same bit
// - paused: data-out high impedance, data-in ignored
// - protect pin high allows normal reads and writes
// - protect pin low with gate bit set rejects status writes
// - protect pin falling during selected status write aborts it when gate bit set
// - started internal status write is unaffected by protect pin
// - gate bit zero makes protect pin ignored
// - opcode decode with bit 3 don't care, upper nibble zero
// - status bit 0 is one while internal write in progress
module sesp_slave
   import sesp_pkg::*;
#(
   parameter int WRITE_CYCLES = sesp_pkg::SESP_WRITE_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        sck,
   input  wire logic        cs_n,
   input  wire logic        si,
   input  wire logic        hold_n,
   input  wire logic        wp_n,
   output logic             so_out,
   output logic             so_oe_n,
   output logic [7:0]       status_o,
   output logic             busy_o,
   output logic [15:0]      mem_addr_o,
   input  wire logic [7:0]  mem_rd_data,
   output logic             mem_wr_en_o,
   output logic [7:0]       mem_wr_data_o
);
   import sesp_pkg::*;

   typedef struct packed {
      logic [SESP_NPINS-1:0] meta;
      logic [SESP_NPINS-1:0] sync;
      logic                  sck_p;
      logic                  cs_p;
      logic                  wp_p;
      sesp_state_t           st;
      logic                  wr_mode;
      logic [2:0]            bit_cnt;
      logic [7:0]            rx;
      logic [7:0]            tx;
      logic                  so;
      logic                  drive;
      logic                  oe_n;
      logic                  paused;
      logic [15:0]           addr;
      logic [1:0]            addr_bytes;
      logic                  sr_ok;
      logic                  sr_abort;
      logic [7:0]            sr_new;
      logic                  wr_any;
      logic                  wen;
      logic                  gate;
      logic                  bp1;
      logic                  bp0;
      logic [SESP_BUSY_W-1:0] busy_cnt;
      logic                  mem_we;
      logic [7:0]            mem_wd;
   } sesp_regs_t;

   sesp_regs_t q;
   sesp_regs_t d;

   logic       sck_s;
   logic       cs_s;
   logic       si_s;
   logic       hold_s;
   logic       wp_s;
   logic       rise;
   logic       fall;
   logic       busy;
   logic [7:0] sr_byte;
   logic [7:0] rx_byte;
   logic [7:0] src;

   always_comb begin
      sck_s   = q.sync[SESP_P_SCK];
      cs_s    = q.sync[SESP_P_CS];
      si_s    = q.sync[SESP_P_SI];
      hold_s  = q.sync[SESP_P_HOLD];
      wp_s    = q.sync[SESP_P_WP];
      rise    = sck_s & ~q.sck_p;
      fall    = ~sck_s & q.sck_p;
      busy    = (q.busy_cnt != '0);
      sr_byte = '0;
      sr_byte[SESP_SR_GATE] = q.gate;
      sr_byte[SESP_SR_BP1]  = q.bp1;
      sr_byte[SESP_SR_BP0]  = q.bp0;
      sr_byte[SESP_SR_WEN]  = q.wen;
      sr_byte[SESP_SR_RDY]  = busy;
      if (busy) begin
         sr_byte = SESP_SR_BUSY_BYTE;
      end
      rx_byte = {q.rx[6:0], si_s};
      src     = (q.st == SESP_RD_STATUS) ? sr_byte : mem_rd_data;

      d        = q;
      d.meta   = {wp_n, hold_n, si, cs_n, sck};
      d.sync   = q.meta;
      d.sck_p  = sck_s;
      d.cs_p   = cs_s;
      d.wp_p   = wp_s;
      d.mem_we = 1'b0;
      // address advances the cycle after a byte write pulse
      if (q.mem_we) begin
         d.addr = q.addr + 1'b1;
      end
      if (busy) begin
         d.busy_cnt = q.busy_cnt - 1'b1;
      end

      if (cs_s) begin
         // deselected: commit pending writes on the rising select
         if (!q.cs_p) begin
            if (q.st == SESP_WR_STATUS && q.sr_ok && !q.sr_abort && q.wen
                && !(q.gate && !wp_s)) begin
               d.gate     = q.sr_new[SESP_SR_GATE];
               d.bp1      = q.sr_new[SESP_SR_BP1];
               d.bp0      = q.sr_new[SESP_SR_BP0];
               d.wen      = 1'b0;
               d.busy_cnt = SESP_BUSY_W'(WRITE_CYCLES);
            end
            if (q.st == SESP_WR_ARRAY && q.wr_any && q.wen) begin
               d.wen      = 1'b0;
               d.busy_cnt = SESP_BUSY_W'(WRITE_CYCLES);
            end
         end
         d.st      = SESP_OPCODE;
         d.bit_cnt = '0;
         d.drive   = 1'b0;
         d.paused  = 1'b0;
      end else if (q.cs_p) begin
         d.st         = SESP_OPCODE;
         d.bit_cnt    = '0;
         d.addr_bytes = '0;
         d.sr_ok      = 1'b0;
         d.sr_abort   = 1'b0;
         d.wr_any     = 1'b0;
         d.paused     = 1'b0;
         d.drive      = 1'b0;
      end else begin
         if (q.st == SESP_WR_STATUS && q.wp_p && !wp_s && q.gate) begin
            d.sr_abort = 1'b1;
         end
         if (!sck_s) begin
            d.paused = !hold_s;
         end
         if (!q.paused && q.st != SESP_INVALID) begin
            if (rise) begin
               d.rx      = rx_byte;
               d.bit_cnt = q.bit_cnt + 1'b1;
               if (q.bit_cnt == SESP_LAST_BIT) begin
                  case (q.st)
                     SESP_OPCODE: begin
                        d.st = SESP_INVALID;
                        if (busy) begin
                           if ((rx_byte & SESP_OPC_MASK)
                               == SESP_READ_STATUS_CMD) begin
                              d.st = SESP_RD_STATUS;
                           end
                        end else begin
                           case (rx_byte & SESP_OPC_MASK)
                              SESP_SET_WRITE_LATCH_CMD: begin
                                 d.wen = 1'b1;
                                 d.st  = SESP_DONE;
                              end
                              SESP_CLR_WRITE_LATCH_CMD: begin
                                 d.wen = 1'b0;
                                 d.st  = SESP_DONE;
                              end
                              SESP_READ_STATUS_CMD: d.st = SESP_RD_STATUS;
                              SESP_WRITE_STATUS_CMD: d.st = SESP_WR_STATUS;
                              SESP_READ_ARRAY_CMD: begin
                                 d.st      = SESP_ADDR;
                                 d.wr_mode = 1'b0;
                              end
                              SESP_WRITE_ARRAY_CMD: begin
                                 d.st      = SESP_ADDR;
                                 d.wr_mode = 1'b1;
                              end
                              default: d.st = SESP_INVALID;
                           endcase
                        end
                     end
                     SESP_ADDR: begin
                        d.addr       = {q.addr[7:0], rx_byte};
                        d.addr_bytes = q.addr_bytes + 1'b1;
                        if (q.addr_bytes == SESP_LAST_ADDR) begin
                           d.st = q.wr_mode ? SESP_WR_ARRAY : SESP_RD_ARRAY;
                        end
                     end
                     SESP_WR_STATUS: begin
                        if (!q.sr_ok) begin
                           d.sr_new = rx_byte;
                           d.sr_ok  = 1'b1;
                        end
                     end
                     SESP_WR_ARRAY: begin
                        if (q.wen) begin
                           d.mem_we = 1'b1;
                           d.mem_wd = rx_byte;
                           d.wr_any = 1'b1;
                        end
                     end
                     default: d.st = q.st;
                  endcase
               end
            end
            if (fall && (q.st == SESP_RD_STATUS ||
                         q.st == SESP_RD_ARRAY)) begin
               d.drive = 1'b1;
               if (q.bit_cnt == '0) begin
                  d.so = src[7];
                  d.tx = {src[6:0], 1'b0};
                  if (q.st == SESP_RD_ARRAY) begin
                     d.addr = q.addr + 1'b1;
                  end
               end else begin
                  d.so = q.tx[7];
                  d.tx = {q.tx[6:0], 1'b0};
               end
            end
         end
         if (q.st == SESP_INVALID) begin
            d.drive = 1'b0;
         end
      end
      d.oe_n = !(d.drive && !d.paused && !cs_s);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q      <= '0;
         q.oe_n <= 1'b1;
         q.sck_p <= 1'b0;
         q.cs_p <= 1'b1;
         q.wp_p <= 1'b1;
         // idle-high pins start high, so no false edge after reset
         q.meta[SESP_P_CS]   <= 1'b1;
         q.meta[SESP_P_HOLD] <= 1'b1;
         q.meta[SESP_P_WP]   <= 1'b1;
         q.sync[SESP_P_CS]   <= 1'b1;
         q.sync[SESP_P_HOLD] <= 1'b1;
         q.sync[SESP_P_WP]   <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign so_out        = q.so;
   assign so_oe_n       = q.oe_n;
   assign status_o      = sr_byte;
   assign busy_o        = busy;
   assign mem_addr_o    = q.addr;
   assign mem_wr_en_o   = q.mem_we;
   assign mem_wr_data_o = q.mem_wd;

endmodule

// ---- pkg/sesp_pkg.sv ----
package sesp_pkg;

   // opcodes after masking the don't-care bit
   localparam logic [7:0] SESP_OPC_MASK           = 8'hF7;
   localparam logic [7:0] SESP_SET_WRITE_LATCH_CMD = 8'h06;
   localparam logic [7:0] SESP_CLR_WRITE_LATCH_CMD = 8'h04;
   localparam logic [7:0] SESP_READ_STATUS_CMD    = 8'h05;
   localparam logic [7:0] SESP_WRITE_STATUS_CMD   = 8'h01;
   localparam logic [7:0] SESP_READ_ARRAY_CMD     = 8'h03;
   localparam logic [7:0] SESP_WRITE_ARRAY_CMD    = 8'h02;

   // status byte layout
   localparam int SESP_SR_RDY  = 0;
   localparam int SESP_SR_WEN  = 1;
   localparam int SESP_SR_BP0  = 2;
   localparam int SESP_SR_BP1  = 3;
   localparam int SESP_SR_GATE = 7;
   localparam logic [7:0] SESP_SR_BUSY_BYTE = 8'hFF;

   // pin positions in the synchroniser vectors
   localparam int SESP_P_SCK  = 0;
   localparam int SESP_P_CS   = 1;
   localparam int SESP_P_SI   = 2;
   localparam int SESP_P_HOLD = 3;
   localparam int SESP_P_WP   = 4;
   localparam int SESP_NPINS  = 5;

   localparam logic [2:0] SESP_LAST_BIT  = 3'h7;
   localparam logic [1:0] SESP_LAST_ADDR = 2'h1;

   // self-timed write cycle
   localparam int SESP_CLK_MHZ       = 100;
   localparam int SESP_WRITE_TIME_US = 5000;
   localparam int SESP_WRITE_CYCLES  = SESP_WRITE_TIME_US * SESP_CLK_MHZ;
   localparam int SESP_BUSY_W        = 20;

   typedef enum logic [2:0] {
      SESP_OPCODE,
      SESP_ADDR,
      SESP_RD_ARRAY,
      SESP_WR_ARRAY,
      SESP_RD_STATUS,
      SESP_WR_STATUS,
      SESP_DONE,
      SESP_INVALID
   } sesp_state_t;

endpackage

// ---- sim/sesp_slave_assertions.sv ----
`timescale 1ns/1ps
module sesp_checker #(
   parameter int WRITE_CYCLES = 20
) (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       sck,
   input wire logic       cs_n,
   input wire logic       hold_n,
   input wire logic       so_oe_n,
   input wire logic [7:0] status_o,
   input wire logic       busy_o,
   input wire logic       mem_wr_en_o
);
   int cnt_q;
   // counts consecutive busy cycles
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n) cnt_q <= 0;
      else cnt_q <= busy_o ? cnt_q + 1 : 0;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_rdy; status_o[0] == busy_o; endproperty
   a_rdy: assert property (p_rdy) else $error("ready bit");
   property p_ff; busy_o |-> status_o == 8'hFF; endproperty
   a_ff: assert property (p_ff) else $error("busy byte");
   property p_len;
      $fell(busy_o) && cnt_q != 0 |-> cnt_q == WRITE_CYCLES;
   endproperty
   a_len: assert property (p_len) else $error("busy length");
   property p_desel; cs_n [*5] |-> so_oe_n; endproperty
   a_desel: assert property (p_desel) else $error("driven when idle");
   property p_pause; (!hold_n && !sck) [*5] |-> so_oe_n; endproperty
   a_pause: assert property (p_pause) else $error("driven in pause");
   property p_oe; $fell(so_oe_n) |-> !$past(sck, 2); endproperty
   a_oe: assert property (p_oe) else $error("drive not after fall");
   property p_pulse; mem_wr_en_o |=> !mem_wr_en_o; endproperty
   a_pulse: assert property (p_pulse) else $error("long write");
   property p_start; $rose(busy_o) |-> cs_n && $past(cs_n); endproperty
   a_start: assert property (p_start) else $error("early write");
endmodule
bind sesp_slave sesp_checker #(.WRITE_CYCLES(WRITE_CYCLES)) i_chk (
   .clk, .rst_n, .sck, .cs_n, .hold_n, .so_oe_n, .status_o, .busy_o,
   .mem_wr_en_o
);

// ---- sim/sesp_master_model.sv ----
`timescale 1ns/1ps
module sesp_master_model (
   input  wire logic clk,
   input  wire logic so_out,
   input  wire logic so_oe_n,
   output logic      sck,
   output logic      cs_n,
   output logic      si,
   output logic      hold_n
);
   logic [7:0] rx;
   logic       last_q = 1'b0;
   logic       so_line;
   always @(posedge clk) if (!so_oe_n) last_q <= so_out;
   // released line shows the inverse of its last driven value
   assign so_line = so_oe_n ? ~last_q : so_out;
   initial {sck, cs_n, si, hold_n} = 4'b0101;
   task automatic set(input logic c, input logic h);
      cs_n = c;
      hold_n = h;
      si = ~si;
      repeat (6) @(negedge clk);
   endtask
   task automatic xfer(input logic [31:0] w, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         si = w[i];
         repeat (4) @(negedge clk);
         sck = 1'b1;
         rx = {rx[6:0], so_line};
         repeat (4) @(negedge clk);
         sck = 1'b0;
      end
   endtask
   task automatic frame(input logic [31:0] w, input int n);
      set(1'b0, 1'b1);
      xfer(w, n);
      set(1'b1, 1'b1);
   endtask
endmodule

// ---- sim/sesp_slave_tb.sv ----
`timescale 1ns/1ps
module sesp_slave_tb;
   localparam int WC = 400;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        wp_n = 1'b1;
   logic        sck, cs_n, si, hold_n, so_out, so_oe_n, busy_o, mem_wr_en_o;
   logic [7:0]  status_o, mem_rd_data, mem_wr_data_o, r1, wr_d;
   logic [15:0] mem_addr_o, wr_a;
   logic [7:0]  opc [4] = '{8'h06, 8'h04, 8'h0E, 8'h0C};
   logic [7:0]  sd [5] = '{8'h8C, 8'h00, 8'h00, 8'h00, 8'h0C};
   logic [7:0]  se [5] = '{8'h8C, 8'h8C, 8'h8C, 8'h00, 8'h0C};
   logic [2:0]  sw [5] = '{3'h7, 3'h0, 3'h4, 3'h6, 3'h0};
   int          miscompares = 0;
   int          samples_checked = 0;
   assign mem_rd_data = mem_addr_o[7:0] ^ 8'hA5;
   always @(posedge clk)
      if (mem_wr_en_o) {wr_a, wr_d} <= {mem_addr_o, mem_wr_data_o};
   sesp_slave #(.WRITE_CYCLES(WC)) i_dut (
      .clk, .rst_n, .sck, .cs_n, .si, .hold_n, .wp_n, .so_out, .so_oe_n,
      .status_o, .busy_o, .mem_addr_o, .mem_rd_data, .mem_wr_en_o,
      .mem_wr_data_o
   );
   sesp_master_model i_mst (
      .clk, .so_out, .so_oe_n, .sck, .cs_n, .si, .hold_n
   );
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic wait_idle();
      int k;
      for (k = 0; busy_o !== 1'b0 && k < 2 * WC; k++) @(negedge clk);
      chk({7'h0, busy_o}, 8'h00);
      if (k == 2 * WC) report_and_stop();
   endtask
   initial forever #5 clk = ~clk;
   initial begin
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      repeat (6) @(negedge clk);
      chk({7'h0, so_oe_n}, 8'h01);
      i_mst.frame(32'h0706, 16);
      chk(i_mst.rx, 8'hFF);
      i_mst.frame(32'h0500, 16);
      chk(i_mst.rx, 8'h00);
      foreach (opc[i]) begin
         i_mst.frame({24'h0, opc[i]}, 8);
         i_mst.frame(32'h0D00, 16);
         chk(i_mst.rx, opc[i] & 8'h02);
      end
      $display("test opcodes done");
      i_mst.frame(32'h06, 8);
      i_mst.set(1'b0, 1'b1);
      i_mst.xfer(32'h050, 12);
      r1 = i_mst.rx;
      i_mst.set(1'b0, 1'b0);
      i_mst.xfer(32'h3F, 6);
      chk({7'h0, so_oe_n}, 8'h01);
      i_mst.set(1'b0, 1'b1);
      i_mst.xfer(32'h0, 4);
      i_mst.set(1'b1, 1'b1);
      chk({r1[3:0], i_mst.rx[3:0]}, 8'h02);
      $display("test pause done");
      i_mst.set(1'b0, 1'b1);
      i_mst.xfer(32'h03010500, 32);
      chk(i_mst.rx, 8'hA0);
      i_mst.xfer(32'h0, 8);
      chk(i_mst.rx, 8'hA3);
      i_mst.set(1'b1, 1'b1);
      i_mst.frame(32'h06, 8);
      i_mst.frame(32'h0201053C, 32);
      chk(wr_d, 8'h3C);
      chk({wr_a[11:8], wr_a[3:0]}, 8'h15);
      i_mst.frame(32'h0500, 16);
      chk(i_mst.rx, 8'hFF);
      wait_idle();
      $display("test array done");
      foreach (sd[i]) begin
         wp_n = sw[i][2];
         i_mst.frame(32'h06, 8);
         i_mst.set(1'b0, 1'b1);
         i_mst.xfer({24'h01, sd[i]}, 16);
         wp_n = sw[i][1];
         repeat (4) @(negedge clk);
         // back to the first level: the middle level may stop the write only through the abort
         wp_n = sw[i][2];
         i_mst.set(1'b1, 1'b1);
         wp_n = sw[i][0];
         wait_idle();
         chk(status_o & 8'hFD, se[i]);
      end
      $display("test protect done");
      report_and_stop();
   end
endmodule
